// ==== hw/cso_pkg.sv ====
// Constants for the capacitive sense oscillator control block.
// Assumes an 8-bit register port with a 3-bit word address.
`default_nettype none
package cso_pkg;
   // ==========================================================
   // Register addresses
   localparam logic [2:0] CSO_ADDR_PRIMARY = 3'h0;
   localparam logic [2:0] CSO_ADDR_CHANNEL = 3'h1;
   localparam logic [2:0] CSO_ADDR_T1_CTRL = 3'h2;
   localparam logic [2:0] CSO_ADDR_T1_GATE = 3'h3;
   localparam logic [2:0] CSO_ADDR_T1_LOW = 3'h4;
   localparam logic [2:0] CSO_ADDR_T1_HIGH = 3'h5;
   localparam logic [2:0] CSO_ADDR_T0_COUNT = 3'h6;
   localparam logic [2:0] CSO_ADDR_T0_OPTION = 3'h7;
   // ==========================================================
   // Field positions
   localparam int CSO_BIT_ENABLE = 7;
   localparam int CSO_BIT_RANGE_HI = 3;
   localparam int CSO_BIT_RANGE_LO = 2;
   localparam int CSO_BIT_DIR = 1;
   localparam int CSO_BIT_TIMER_ZERO_EXT_SOURCE_SELECT = 0;
   localparam int CSO_BIT_CH_HI = 2;
   localparam int CSO_BIT_T1CS_HI = 7;
   localparam int CSO_BIT_T1CS_LO = 6;
   localparam int CSO_BIT_T1RUN = 0;
   localparam int CSO_BIT_T1GE = 7;
   localparam int CSO_BIT_TIMER_ONE_GATE_TOGGLE = 5;
   localparam int CSO_BIT_GATE_VAL = 2;
   localparam int CSO_BIT_GSS_HI = 1;
   localparam int CSO_BIT_TIMER_ZERO_CLOCK_SELECT = 5;
   // ==========================================================
   // Encodings and reset values
   localparam logic [1:0] CSO_RANGE_OFF = 2'h0;
   localparam logic [1:0] CSO_T1CS_INSTR = 2'h0;
   localparam logic [1:0] CSO_T1CS_OSC = 2'h3;
   localparam logic [1:0] CSO_GSS_WDT = 2'h3;
   localparam logic [7:0] CSO_RESET_BYTE = 8'h00;
   localparam int CSO_CHANNELS = 8;
endpackage
`default_nettype wire

// ==== hw/cso_sense_ctrl.sv ====
// Capacitive sense oscillator control: registers, channel mux, timers, watchdog gate.
// Assumes all inputs are synchronous to sys_clk and the oscillator direction is a level.
//
// Summary of operation
// R1 - The oscillator keeps running while sensing is enabled with a nonzero range, whether or not the part sleeps.
// R2 - Gate source select 11 makes the watchdog overflow the gate of timer one.
// R3 - In toggle mode with the watchdog gate, timer one counts from one overflow to the next.
// R4 - Software arms gating, enables sensing and clears timer one before it sleeps.
// R5 - Timer zero does not count while the part sleeps.
// R6 - An early wake from another source restarts the watchdog, delaying its next overflow.
// R7 - With sensing disabled the channel field is ignored and no pin is connected.
// R8 - With sensing enabled the channel field connects the pin of the same index.
// R9 - Range 00 turns the oscillator off; 01, 10 and 11 select low, medium and high current.
// R10 - The selected count timer advances once per oscillator cycle.
// R11 - Software clears the count timer at each time base start and reads it at the end.
// R12 - Timer zero counts oscillator cycles when its external source and clock selects allow.
// R13 - Timer one clock source 11 makes the oscillator its clock.
// R14 - The direction status bit shows whether the oscillator sources or sinks current.
// R15 - The direction bit ignores writes and unimplemented bits read as zero.
`default_nettype none
module cso_sense_ctrl
   import cso_pkg::*;
#(
   parameter int WDT_CYCLES = 4096
) (
   input wire logic sys_clk, // System clock
   input wire logic reset, // Synchronous reset, active high
   input wire logic clk_en, // Freezes all state while low
   input wire logic [2:0] reg_addr, // Register address
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [7:0] reg_rdata, // Read data, cycle after strobe
   input wire logic osc_dir_in, // Oscillator sourcing (1) or sinking (0)
   input wire logic sleep_req, // Part is asleep
   input wire logic wake_other, // Wake pulse from a non-watchdog source
   input wire logic t1_gate_pin, // Timer one external gate level
   output logic [7:0] sense_input_pin, // One-hot pin connect
   output logic [1:0] osc_current_range, // Current range to the oscillator
   output logic osc_run, // Oscillator enable
   output logic watchdog_overflow // Watchdog overflow pulse
);
   localparam int WDT_W = $clog2(WDT_CYCLES);
   localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_CYCLES - 1);

   // Refuse a watchdog period the overflow pulse logic cannot serve
   if (WDT_CYCLES < 2) begin
      $error("WDT_CYCLES must be at least 2");
   end

   // ==========================================================
   // State
   typedef struct packed {
      logic en;
      logic [1:0] rng;
      logic dir;
      logic timer_zero_ext_source_select;
      logic [2:0] ch;
      logic [1:0] t1cs;
      logic t1run;
      logic t1ge;
      logic timer_one_gate_toggle;
      logic [1:0] timer_one_gate_source_select;
      logic gate;
      logic timer_zero_clock_select;
      logic [15:0] tmr1;
      logic [7:0] tmr0;
      logic dir_q;
      logic [WDT_W-1:0] wdt_cnt;
      logic wdt_ovf;
      logic [7:0] rdata;
      logic [7:0] pin_sel;
      logic [1:0] rng_out;
      logic osc_on;
   } cso_state_s;

   cso_state_s st;
   cso_state_s next_st;

   function automatic logic [7:0] cso_onehot(input logic [2:0] idx);
      cso_onehot = 8'h01 << idx;
   endfunction

   // ==========================================================
   // Next state
   always_comb begin
      logic osc_edge;
      logic gate_now;
      logic t1_tick;
      logic t1_cnt_en;
      logic wr_p;
      osc_edge = 1'b0;
      gate_now = 1'b0;
      t1_tick = 1'b0;
      t1_cnt_en = 1'b0;
      wr_p = 1'b0;
      next_st = st;
      next_st.dir_q = osc_dir_in;
      next_st.dir = osc_dir_in; // R14
      // One oscillator cycle per rising direction edge while running
      osc_edge = st.osc_on && osc_dir_in && !st.dir_q; // R10

      // Watchdog: early wake restarts the period
      next_st.wdt_ovf = 1'b0;
      if (wake_other) begin
         next_st.wdt_cnt = '0; // R6
      end else if (st.wdt_cnt == WDT_LAST) begin
         next_st.wdt_cnt = '0;
         next_st.wdt_ovf = 1'b1;
      end else begin
         next_st.wdt_cnt = st.wdt_cnt + 1'b1;
      end

      // Timer one gate
      if (st.timer_one_gate_source_select == CSO_GSS_WDT) begin // R2
         if (st.timer_one_gate_toggle) begin
            if (st.wdt_ovf) begin
               next_st.gate = !st.gate; // R3
            end
         end else begin
            next_st.gate = st.wdt_ovf;
         end
      end else if (st.timer_one_gate_toggle) begin
         next_st.gate = st.gate;
      end else begin
         next_st.gate = t1_gate_pin;
      end
      gate_now = st.gate;
      if (!st.timer_one_gate_toggle && st.timer_one_gate_source_select != CSO_GSS_WDT) begin
         gate_now = t1_gate_pin;
      end

      // Timer one
      if (st.t1cs == CSO_T1CS_OSC) begin
         t1_tick = osc_edge; // R13
      end else if (st.t1cs == CSO_T1CS_INSTR) begin
         t1_tick = !sleep_req;
      end
      t1_cnt_en = st.t1run && (!st.t1ge || gate_now); // R3
      if (t1_cnt_en && t1_tick) begin
         next_st.tmr1 = st.tmr1 + 16'h0001; // R10
      end

      // Timer zero: oscillator clocked, frozen in sleep
      if (st.timer_zero_ext_source_select && !st.timer_zero_clock_select && osc_edge && !sleep_req) begin // R12 R5
         next_st.tmr0 = st.tmr0 + 8'h01;
      end

      // Register writes
      wr_p = reg_wr;
      if (wr_p) begin
         unique case (reg_addr)
            CSO_ADDR_PRIMARY: begin
               next_st.en = reg_wdata[CSO_BIT_ENABLE];
               next_st.rng = reg_wdata[CSO_BIT_RANGE_HI:CSO_BIT_RANGE_LO];
               next_st.timer_zero_ext_source_select = reg_wdata[CSO_BIT_TIMER_ZERO_EXT_SOURCE_SELECT]; // R15
            end
            CSO_ADDR_CHANNEL: begin
               next_st.ch = reg_wdata[CSO_BIT_CH_HI:0];
            end
            CSO_ADDR_T1_CTRL: begin
               next_st.t1cs = reg_wdata[CSO_BIT_T1CS_HI:CSO_BIT_T1CS_LO];
               next_st.t1run = reg_wdata[CSO_BIT_T1RUN];
            end
            CSO_ADDR_T1_GATE: begin
               next_st.t1ge = reg_wdata[CSO_BIT_T1GE];
               next_st.timer_one_gate_toggle = reg_wdata[CSO_BIT_TIMER_ONE_GATE_TOGGLE];
               next_st.timer_one_gate_source_select = reg_wdata[CSO_BIT_GSS_HI:0];
            end
            CSO_ADDR_T1_LOW: begin
               next_st.tmr1[7:0] = reg_wdata; // R11
            end
            CSO_ADDR_T1_HIGH: begin
               next_st.tmr1[15:8] = reg_wdata; // R11
            end
            CSO_ADDR_T0_COUNT: begin
               next_st.tmr0 = reg_wdata;
            end
            CSO_ADDR_T0_OPTION: begin
               next_st.timer_zero_clock_select = reg_wdata[CSO_BIT_TIMER_ZERO_CLOCK_SELECT];
            end
         endcase
      end

      // Register reads: data stands in the following cycle only
      next_st.rdata = CSO_RESET_BYTE;
      if (reg_rd) begin
         unique case (reg_addr)
            CSO_ADDR_PRIMARY: begin
               next_st.rdata[CSO_BIT_ENABLE] = st.en;
               next_st.rdata[CSO_BIT_RANGE_HI:CSO_BIT_RANGE_LO] = st.rng;
               next_st.rdata[CSO_BIT_DIR] = st.dir; // R14
               next_st.rdata[CSO_BIT_TIMER_ZERO_EXT_SOURCE_SELECT] = st.timer_zero_ext_source_select;
            end
            CSO_ADDR_CHANNEL: begin
               next_st.rdata[CSO_BIT_CH_HI:0] = st.ch; // R15
            end
            CSO_ADDR_T1_CTRL: begin
               next_st.rdata[CSO_BIT_T1CS_HI:CSO_BIT_T1CS_LO] = st.t1cs;
               next_st.rdata[CSO_BIT_T1RUN] = st.t1run;
            end
            CSO_ADDR_T1_GATE: begin
               next_st.rdata[CSO_BIT_T1GE] = st.t1ge;
               next_st.rdata[CSO_BIT_TIMER_ONE_GATE_TOGGLE] = st.timer_one_gate_toggle;
               next_st.rdata[CSO_BIT_GATE_VAL] = gate_now;
               next_st.rdata[CSO_BIT_GSS_HI:0] = st.timer_one_gate_source_select;
            end
            CSO_ADDR_T1_LOW: begin
               next_st.rdata = st.tmr1[7:0];
            end
            CSO_ADDR_T1_HIGH: begin
               next_st.rdata = st.tmr1[15:8];
            end
            CSO_ADDR_T0_COUNT: begin
               next_st.rdata = st.tmr0;
            end
            CSO_ADDR_T0_OPTION: begin
               next_st.rdata[CSO_BIT_TIMER_ZERO_CLOCK_SELECT] = st.timer_zero_clock_select;
            end
         endcase
      end

      // Analog side: sleep plays no part here
      next_st.osc_on = next_st.en && (next_st.rng != CSO_RANGE_OFF); // R1 R9
      next_st.rng_out = next_st.en ? next_st.rng : CSO_RANGE_OFF; // R9
      next_st.pin_sel = next_st.en ? cso_onehot(next_st.ch) : CSO_RESET_BYTE; // R7 R8
   end

   // ==========================================================
   // Registers
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign sense_input_pin = st.pin_sel;
   assign osc_current_range = st.rng_out;
   assign osc_run = st.osc_on;
   assign watchdog_overflow = st.wdt_ovf;
endmodule
`default_nettype wire

// ==== sim/cso_pad_model.sv ====
// Touch pad model: makes bursts of oscillator direction cycles.
// Assumes the bench gives burst length and half period with a go pulse.
`default_nettype none
module cso_pad_model (
   input wire logic sys_clk, // Clock
   input wire logic osc_run, // Oscillator enable
   input wire logic go, // Start a burst
   input wire logic [7:0] n_osc, // Cycles in burst
   input wire logic [3:0] half, // Half period in clocks
   output logic osc_dir // Direction level
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] left = 0;
   logic [3:0] cnt = 0;
   initial osc_dir = 0;
   // Triangle stands still when idle or when the oscillator is off
   always @(posedge sys_clk) begin
      if (go) begin
         left <= {n_osc, 1'b0};
         cnt <= 0;
      end else if (left != 0 && osc_run) begin
         cnt <= (cnt == half - 1) ? 4'h0 : cnt + 4'h1;
         if (cnt == half - 1) begin
            osc_dir <= !osc_dir;
            left <= left - 9'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== sim/cso_sense_props.sv ====
// Port checks for the sense control block.
// Assumes binding onto cso_sense_ctrl with clk_en high.
`default_nettype none
module cso_sense_props
   import cso_pkg::*;
#(
   parameter int WDT_CYCLES = 4096
) (
   input wire logic sys_clk, // Clk
   input wire logic reset, // Rst
   input wire logic clk_en, // En
   input wire logic [2:0] reg_addr, // Addr
   input wire logic [7:0] reg_wdata, // Wdata
   input wire logic reg_wr, // Wr
   input wire logic reg_rd, // Rd
   input wire logic [7:0] reg_rdata, // Rdata
   input wire logic osc_dir_in, // Dir
   input wire logic sleep_req, // Sleep
   input wire logic wake_other, // Wake
   input wire logic t1_gate_pin, // Gate
   input wire logic [7:0] sense_input_pin, // Pins
   input wire logic [1:0] osc_current_range, // Range
   input wire logic osc_run, // Run
   input wire logic watchdog_overflow // Ovf
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // ===
   // Sequences
   sequence s_wr0;
      clk_en && reg_wr && reg_addr == CSO_ADDR_PRIMARY;
   endsequence
   sequence s_rd(logic [2:0] a);
      clk_en && reg_rd && reg_addr == a;
   endsequence
   // ===
   // Properties
   property p_off;
      s_wr0 ##0 !reg_wdata[7] |=> sense_input_pin == 8'h00 && !osc_run;
   endproperty
   property p_onehot;
      $onehot0(sense_input_pin);
   endproperty
   property p_range;
      s_wr0 |=> osc_current_range == ($past(reg_wdata[7]) ? $past(reg_wdata[3:2]) : 2'h0);
   endproperty
   property p_run;
      s_wr0 |=> osc_run == ($past(reg_wdata[7]) && $past(reg_wdata[3:2]) != 2'h0);
   endproperty
   property p_sleep;
      sleep_req && !reg_wr |=> $stable(osc_run);
   endproperty
   property p_pulse;
      clk_en && watchdog_overflow |=> !watchdog_overflow;
   endproperty
   property p_wake;
      clk_en && wake_other |=> !watchdog_overflow [*8];
   endproperty
   property p_rsv0;
      s_rd(CSO_ADDR_PRIMARY) |=> reg_rdata[6:4] == 3'h0;
   endproperty
   property p_rsv1;
      s_rd(CSO_ADDR_CHANNEL) |=> reg_rdata[7:3] == 5'h0;
   endproperty
   property p_dir;
      s_rd(CSO_ADDR_PRIMARY) |=> reg_rdata[CSO_BIT_DIR] == $past(osc_dir_in, 2);
   endproperty
   a_off: assert property (p_off) else $error("pin on while off");
   a_onehot: assert property (p_onehot) else $error("pins not one-hot");
   a_range: assert property (p_range) else $error("bad range");
   a_run: assert property (p_run) else $error("bad run");
   a_sleep: assert property (p_sleep) else $error("sleep moved run");
   a_pulse: assert property (p_pulse) else $error("long overflow");
   a_wake: assert property (p_wake) else $error("overflow after wake");
   a_rsv0: assert property (p_rsv0) else $error("primary spare bits");
   a_rsv1: assert property (p_rsv1) else $error("channel spare bits");
   a_dir: assert property (p_dir) else $error("direction bit wrong");
endmodule
bind cso_sense_ctrl cso_sense_props #(.WDT_CYCLES(WDT_CYCLES)) props_u (
   .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .osc_dir_in(osc_dir_in), .sleep_req(sleep_req), .wake_other(wake_other),
   .t1_gate_pin(t1_gate_pin), .sense_input_pin(sense_input_pin),
   .osc_current_range(osc_current_range), .osc_run(osc_run),
   .watchdog_overflow(watchdog_overflow));
`default_nettype wire

// ==== sim/cso_sense_ctrl_test.sv ====
// Self-checking bench for the sense control block.
// Assumes the pad model and the bound checker are compiled alongside.
`default_nettype none
module cso_sense_ctrl_test;
   import cso_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int WDT = 16;
   logic sys_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, sleep_req = 0, wake_other = 0;
   logic go = 0, clk_en = 1, osc_dir_in, osc_run, watchdog_overflow;
   logic [2:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0, reg_rdata, sense_input_pin, n_osc = 0, d;
   logic [3:0] half = 1;
   logic [1:0] osc_current_range;
   int n_fail = 0, tests_run = 0, n;
   cso_sense_ctrl #(.WDT_CYCLES(WDT)) dut_u (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .osc_dir_in(osc_dir_in), .sleep_req(sleep_req),
      .wake_other(wake_other), .t1_gate_pin(1'b0), .sense_input_pin(sense_input_pin),
      .osc_current_range(osc_current_range), .osc_run(osc_run),
      .watchdog_overflow(watchdog_overflow));
   cso_pad_model pad_u (.sys_clk(sys_clk), .osc_run(osc_run), .go(go), .n_osc(n_osc),
      .half(half), .osc_dir(osc_dir_in));
   initial forever #5 sys_clk = ~sys_clk;
   // ===
   // Shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 0;
      #1;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge sys_clk);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 0;
      #1 d = reg_rdata;
   endtask
   task automatic burst(input logic [7:0] c, input logic [3:0] h);
      @(posedge sys_clk);
      go <= 1;
      n_osc <= c;
      half <= h;
      @(posedge sys_clk);
      go <= 0;
      repeat (2 * c * h + 4) @(posedge sys_clk);
   endtask
   task automatic wait_ov;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (watchdog_overflow !== 1'b1 && n < 100);
      if (n >= 100) begin
         chk(8'h00, 8'h01);
         report_and_stop;
      end
   endtask
   // ===
   // Scenarios
   task automatic t_regs;
      for (int a = 0; a < 8; a++) begin
         rd(a[2:0]);
         chk(d, 8'h00);
      end
      for (int c = 0; c < 8; c++) begin
         wr(CSO_ADDR_CHANNEL, 8'(c));
         wr(CSO_ADDR_PRIMARY, {1'b1, 3'h0, 2'(c), 2'h0});
         chk(sense_input_pin, 8'h1 << c);
         chk({6'h0, osc_current_range}, 8'(c % 4));
         chk({7'h0, osc_run}, 8'(c % 4 != 0));
      end
      wr(CSO_ADDR_PRIMARY, 8'h0c);
      chk(sense_input_pin, 8'h00);
      wr(CSO_ADDR_PRIMARY, 8'hff);
      rd(CSO_ADDR_PRIMARY);
      chk(d, 8'h8d);
      wr(CSO_ADDR_CHANNEL, 8'hff);
      rd(CSO_ADDR_CHANNEL);
      chk(d, 8'h07);
   endtask
   task automatic t_t1(input logic [7:0] c, input logic [3:0] h);
      wr(CSO_ADDR_T1_GATE, 8'h00);
      wr(CSO_ADDR_T1_CTRL, 8'hc1);
      wr(CSO_ADDR_PRIMARY, 8'h84);
      wr(CSO_ADDR_T1_LOW, 8'h00);
      wr(CSO_ADDR_T1_HIGH, 8'h00);
      burst(c, h);
      rd(CSO_ADDR_T1_LOW);
      chk(d, c);
   endtask
   // Clock enable low: oscillator cycles must not reach timer one
   task automatic t_freeze;
      wr(CSO_ADDR_T1_GATE, 8'h00);
      wr(CSO_ADDR_T1_CTRL, 8'hc1);
      wr(CSO_ADDR_PRIMARY, 8'h84);
      wr(CSO_ADDR_T1_LOW, 8'h00);
      wr(CSO_ADDR_T1_HIGH, 8'h00);
      @(posedge sys_clk);
      clk_en <= 1'b0;
      burst(8'd4, 4'd1);
      clk_en <= 1'b1;
      rd(CSO_ADDR_T1_LOW);
      chk(d, 8'h00);
   endtask
   // Direction bit read while the pad sits in its sourcing half, then again in its sinking half
   task automatic t_dir;
      @(posedge sys_clk);
      go <= 1;
      n_osc <= 8'd1;
      half <= 4'd8;
      @(posedge sys_clk);
      go <= 0;
      repeat (9) @(posedge sys_clk);
      rd(CSO_ADDR_PRIMARY);
      chk(d & 8'h02, 8'h02);
      repeat (12) @(posedge sys_clk);
      rd(CSO_ADDR_PRIMARY);
      chk(d & 8'h02, 8'h00);
   endtask
   task automatic t_t0;
      wr(CSO_ADDR_T1_CTRL, 8'h00);
      wr(CSO_ADDR_T0_OPTION, 8'h00);
      wr(CSO_ADDR_PRIMARY, 8'h85);
      wr(CSO_ADDR_T0_COUNT, 8'h00);
      burst(8'd4, 4'd2);
      sleep_req <= 1;
      burst(8'd3, 4'd1);
      chk({7'h0, osc_run}, 8'h01);
      sleep_req <= 0;
      rd(CSO_ADDR_T0_COUNT);
      chk(d, 8'h04);
   endtask
   task automatic t_gate;
      // Align to an overflow so the set-up finishes before the next one
      wait_ov;
      wr(CSO_ADDR_T1_GATE, 8'ha3);
      wr(CSO_ADDR_T1_CTRL, 8'hc1);
      wr(CSO_ADDR_PRIMARY, 8'h84);
      wr(CSO_ADDR_T1_LOW, 8'h00);
      wr(CSO_ADDR_T1_HIGH, 8'h00);
      @(posedge sys_clk);
      sleep_req <= 1;
      wait_ov;
      burst(8'd3, 4'd1);
      wait_ov;
      burst(8'd2, 4'd1);
      sleep_req <= 0;
      rd(CSO_ADDR_T1_LOW);
      chk(d, 8'h03);
      wait_ov;
      repeat (6) @(posedge sys_clk);
      wake_other <= 1;
      @(posedge sys_clk);
      wake_other <= 0;
      wait_ov;
      chk(8'(n >= WDT - 2 && n <= WDT + 2), 8'h01);
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      reset <= 0;
      t_regs;
      t_t1(8'd5, 4'd1);
      t_t1(8'd3, 4'd3);
      t_freeze;
      t_t0;
      t_gate;
      t_dir;
      report_and_stop;
   end
endmodule
`default_nettype wire
